// ==== pmepr_regs.sv ====
`timescale 1ns/100ps
// Operation
// - Status flags are sticky; writing one clears, zero leaves unchanged.
// - Status bit 2 set on trapped VGA memory access.
// - Status bit 1 set on trapped VGA I/O access.
// - Status bit 0 set when external management interrupt pin asserts.
// - Writing control bit 5 sends the current packet at once.
// - Bits 4:3 pick 1, 5, 10 ms interval; send only if packet nonzero.
// - Control bit 0 enables video decode event recording.
// - Clock-stop set and suspend asserted gives suspend acknowledge.
// - Packet bit 7 set on vertical sync interrupt flag.
// - Packet bit 6 set on enabled non-fetch cache miss.
// - Packet bit 1 set on programmable address range hit.
// - Serial line low until interval, then high two clocks.
// - Bits 7 to 0 shifted, one-clock end mark, then packet cleared.
// - Packet bits hold until send completes; events accumulate.
// - Packet bit 0 set on enabled display register or memory access.
module pmepr_regs #(
   parameter int CYC_1MS = pmepr_pkg::CYC_1MS,
   parameter int CYC_5MS = pmepr_pkg::CYC_5MS,
   parameter int CYC_10MS = pmepr_pkg::CYC_10MS
) (
   // Clock and reset
   input wire logic CLK_SYS,
   input wire logic RESET_N,
   // Register port
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [15:0] REG_ADDR,
   input wire logic [31:0] REG_WDATA,
   output logic [31:0] REG_RDATA,
   // Trap and pin events
   input wire logic VGA_MEM_TRAP,
   input wire logic VGA_IO_TRAP,
   input wire logic MGMT_IRQ_IN_N,
   // Packet event sources
   input wire logic VERTICAL_IRQ_FLAG,
   input wire logic CACHE_MISS,
   input wire logic CACHE_MISS_WRITE,
   input wire logic CACHE_MISS_IFETCH,
   input wire logic RANGE_HIT,
   input wire logic VIDEO_ACCESS,
   // Suspend
   input wire logic SUSPEND_REQUEST_N,
   output logic SUSPEND_ACK_N,
   output logic CLOCK_HALT_MODE,
   // Serial link
   output logic EVENT_SERIAL_OUT
);
   localparam int CW = 24;

   logic [2:0] status_q;
   logic [4:0] ctrl_q;
   logic clock_halt_mode_q;
   logic [7:0] packet_q;
   logic [CW-1:0] tick_q;
   logic send_test_q;
   logic send_go;
   logic busy;
   logic done;
   logic interval_hit;
   logic [CW-1:0] limit;
   logic [7:0] pkt_set;
   logic miss_ok;
   logic wr_sts, wr_ctl, wr_cstp;
   logic [1:0] send_interval;

   if (CYC_10MS >= (1 << CW) || CYC_1MS < 1 || CYC_5MS < 1 || CYC_10MS < 1) begin
      $error("interval count out of range");
   end

   // ===========================================
   // Address decode
   always_comb begin
      wr_sts = 1'b0;
      wr_ctl = 1'b0;
      wr_cstp = 1'b0;
      if (REG_WR && REG_ADDR == pmepr_pkg::OFS_SMI_EVENT_STATUS) begin
         wr_sts = 1'b1;
      end else if (REG_WR && REG_ADDR == pmepr_pkg::OFS_PACKET_CONTROL_ENABLES) begin
         wr_ctl = 1'b1;
      end else if (REG_WR && REG_ADDR == pmepr_pkg::OFS_CLOCK_STOP_CONTROL) begin
         wr_cstp = 1'b1;
      end
   end

   // ===========================================
   // Status flags: a same-cycle event beats the clear
   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         status_q <= 3'h0;
      end else begin
         status_q <= (status_q & ~(wr_sts ? REG_WDATA[2:0] : 3'h0))
            | {VGA_MEM_TRAP,
               VGA_IO_TRAP,
               !MGMT_IRQ_IN_N};
      end
   end

   // ===========================================
   // Control and clock-stop registers
   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         ctrl_q <= 5'h00;
         clock_halt_mode_q <= 1'b0;
         send_test_q <= 1'b0;
      end else begin
         send_test_q <= wr_ctl && REG_WDATA[pmepr_pkg::CTL_TEST_BIT];
         if (wr_ctl) begin
            ctrl_q <= REG_WDATA[4:0];
         end
         if (wr_cstp) begin
            clock_halt_mode_q <= REG_WDATA[pmepr_pkg::CSTP_BIT];
         end
      end
   end

   assign send_interval = ctrl_q[pmepr_pkg::CTL_FREQ_HI:pmepr_pkg::CTL_FREQ_LO];
   assign CLOCK_HALT_MODE = clock_halt_mode_q;
   // Ack only in clock-stop mode; refresh mode keeps clocks
   assign SUSPEND_ACK_N = !(clock_halt_mode_q && !SUSPEND_REQUEST_N);

   // ===========================================
   // Packet event capture
   always_comb begin
      miss_ok = CACHE_MISS && !CACHE_MISS_IFETCH && ctrl_q[pmepr_pkg::CTL_CPU_BIT]
         && (CACHE_MISS_WRITE || ctrl_q[pmepr_pkg::CTL_RD_BIT]);
      pkt_set = 8'h00;
      pkt_set[pmepr_pkg::PKT_VSYNC_BIT] = VERTICAL_IRQ_FLAG;
      pkt_set[pmepr_pkg::PKT_MISS_BIT] = miss_ok;
      pkt_set[pmepr_pkg::PKT_RANGE_BIT] = RANGE_HIT;
      pkt_set[pmepr_pkg::PKT_VIDEO_BIT] = VIDEO_ACCESS && ctrl_q[pmepr_pkg::CTL_VID_BIT];
   end

   // Cleared as the frame ends; only an event on that very edge is kept
   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         packet_q <= pmepr_pkg::RST_REG8;
      end else if (done) begin
         packet_q <= pkt_set;
      end else begin
         packet_q <= packet_q | pkt_set;
      end
   end

   // ===========================================
   // Interval timer
   always_comb begin
      case (send_interval)
         pmepr_pkg::SEND_1MS: limit = CW'(CYC_1MS - 1);
         pmepr_pkg::SEND_5MS: limit = CW'(CYC_5MS - 1);
         pmepr_pkg::SEND_10MS: limit = CW'(CYC_10MS - 1);
         default: limit = '0;
      endcase
   end

   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         tick_q <= '0;
      end else if (send_interval == pmepr_pkg::SEND_OFF || tick_q >= limit) begin
         tick_q <= '0;
      end else begin
         tick_q <= tick_q + 1'b1;
      end
   end

   assign interval_hit = send_interval != pmepr_pkg::SEND_OFF && tick_q >= limit;
   // A timed send needs a nonzero packet; a test send never does
   // Blocked on the done cycle, when the packet still holds the bits just sent
   assign send_go = !busy && !done && (send_test_q || (interval_hit && packet_q != 8'h00));

   pmepr_serial_tx #(
      .WIDTH(pmepr_pkg::PKT_BITS)
   ) u_tx (
      .CLK_SYS(CLK_SYS),
      .RESET_N(RESET_N),
      .send_go(send_go),
      .send_data(packet_q),
      .busy(busy),
      .done(done),
      .event_serial_out(EVENT_SERIAL_OUT)
   );

   // ===========================================
   // Read data; test bit reads as zero
   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         REG_RDATA <= 32'h0000_0000;
      end else if (!REG_RD) begin
         REG_RDATA <= 32'h0000_0000;
      end else if (REG_ADDR == pmepr_pkg::OFS_SMI_EVENT_STATUS) begin
         REG_RDATA <= {29'h0, status_q};
      end else if (REG_ADDR == pmepr_pkg::OFS_PACKET_CONTROL_ENABLES) begin
         REG_RDATA <= {27'h0, ctrl_q};
      end else if (REG_ADDR == pmepr_pkg::OFS_CLOCK_STOP_CONTROL) begin
         REG_RDATA <= {31'h0, clock_halt_mode_q};
      end else if (REG_ADDR == pmepr_pkg::OFS_EVENT_PACKET) begin
         REG_RDATA <= {24'h0, packet_q};
      end else begin
         REG_RDATA <= 32'h0000_0000;
      end
   end

   // ===========================================
   // Checks
   a_flag_sticky: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      status_q[0] && !wr_sts |=> status_q[0])
      else $error("status flag dropped without clear");
   a_pin_sets_flag: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      !MGMT_IRQ_IN_N |=> status_q[pmepr_pkg::STS_PIN_BIT])
      else $error("pin flag not set");
   a_mem_sets_flag: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      VGA_MEM_TRAP |=> status_q[pmepr_pkg::STS_MEM_BIT])
      else $error("memory trap flag not set");
   a_io_sets_flag: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      VGA_IO_TRAP |=> status_q[pmepr_pkg::STS_IO_BIT])
      else $error("io trap flag not set");
   a_test_starts: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      wr_ctl && REG_WDATA[pmepr_pkg::CTL_TEST_BIT] && !busy |=> ##1 busy)
      else $error("test send did not start");
   a_empty_no_send: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      !send_test_q && packet_q == 8'h00 |-> !send_go)
      else $error("empty packet sent");
   a_ack_mode: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      !clock_halt_mode_q |-> SUSPEND_ACK_N)
      else $error("ack in refresh mode");
   a_vsync_held: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      VERTICAL_IRQ_FLAG ##1 !done |-> packet_q[pmepr_pkg::PKT_VSYNC_BIT])
      else $error("vsync bit not held");
   a_fetch_ignored: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      CACHE_MISS_IFETCH |-> !pkt_set[pmepr_pkg::PKT_MISS_BIT])
      else $error("fetch miss reported");
   c_timed_send: cover property (@(posedge CLK_SYS) disable iff (!RESET_N)
      interval_hit && send_go);
   c_test_send: cover property (@(posedge CLK_SYS) disable iff (!RESET_N) send_test_q);
   c_ack: cover property (@(posedge CLK_SYS) disable iff (!RESET_N) !SUSPEND_ACK_N);
endmodule

// ==== pmepr_pkg.sv ====
package pmepr_pkg;
   // ===========================================
   // Register offsets (byte addresses)
   localparam logic [15:0] OFS_SMI_EVENT_STATUS = 16'h8500;
   localparam logic [15:0] OFS_PACKET_CONTROL_ENABLES = 16'h8504;
   localparam logic [15:0] OFS_CLOCK_STOP_CONTROL = 16'h8508;
   localparam logic [15:0] OFS_EVENT_PACKET = 16'h850C;
   // ===========================================
   // Field positions
   localparam int STS_MEM_BIT = 2;
   localparam int STS_IO_BIT = 1;
   localparam int STS_PIN_BIT = 0;
   localparam int CTL_TEST_BIT = 5;
   localparam int CTL_FREQ_HI = 4;
   localparam int CTL_FREQ_LO = 3;
   localparam int CTL_RD_BIT = 2;
   localparam int CTL_CPU_BIT = 1;
   localparam int CTL_VID_BIT = 0;
   localparam int CSTP_BIT = 0;
   localparam int PKT_VSYNC_BIT = 7;
   localparam int PKT_MISS_BIT = 6;
   localparam int PKT_RANGE_BIT = 1;
   localparam int PKT_VIDEO_BIT = 0;
   // ===========================================
   // Reset values
   localparam logic [7:0] RST_REG8 = 8'h00;
   // ===========================================
   // Interval selects and timing
   localparam logic [1:0] SEND_OFF = 2'h0;
   localparam logic [1:0] SEND_1MS = 2'h1;
   localparam logic [1:0] SEND_5MS = 2'h2;
   localparam logic [1:0] SEND_10MS = 2'h3;
   localparam int CLK_HZ = 25000000;
   localparam int T_1MS_US = 1000;
   localparam int T_5MS_US = 5000;
   localparam int T_10MS_US = 10000;
   localparam int CYC_1MS = T_1MS_US * (CLK_HZ / 1000000);
   localparam int CYC_5MS = T_5MS_US * (CLK_HZ / 1000000);
   localparam int CYC_10MS = T_10MS_US * (CLK_HZ / 1000000);
   localparam int START_CYCLES = 2;
   localparam int PKT_BITS = 8;
   // ===========================================
   // Serial framer states
   typedef enum logic [3:0] {
      SER_IDLE = 4'b0001,
      SER_START = 4'b0010,
      SER_DATA = 4'b0100,
      SER_END = 4'b1000
   } pmepr_ser_t;
endpackage

// ==== pmepr_serial_tx.sv ====
`timescale 1ns/100ps
module pmepr_serial_tx #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input wire logic CLK_SYS,
   input wire logic RESET_N,
   // Packet handoff
   input wire logic send_go,
   input wire logic [WIDTH-1:0] send_data,
   output logic busy,
   output logic done,
   // Link
   output logic event_serial_out
);
   pmepr_pkg::pmepr_ser_t st_q;
   logic [WIDTH-1:0] sh_q;
   logic [3:0] cnt_q;

   // Start mark, WIDTH data bits and end mark, then done a clock later
   localparam int FRAME_CYC = WIDTH + 3;

   // The shifter needs two bits at least; the counter holds at most 15
   if (WIDTH < 2 || WIDTH > 15) begin
      $error("WIDTH out of range");
   end

   assign busy = (st_q != pmepr_pkg::SER_IDLE);

   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         st_q <= pmepr_pkg::SER_IDLE;
         sh_q <= '0;
         cnt_q <= 4'h0;
         event_serial_out <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         case (st_q)
            pmepr_pkg::SER_IDLE: begin
               event_serial_out <= 1'b0;
               if (send_go) begin
                  // Two-clock high start mark
                  st_q <= pmepr_pkg::SER_START;
                  sh_q <= send_data;
                  cnt_q <= 4'(pmepr_pkg::START_CYCLES - 1);
                  event_serial_out <= 1'b1;
               end
            end
            pmepr_pkg::SER_START: begin
               if (cnt_q == 4'h0) begin
                  st_q <= pmepr_pkg::SER_DATA;
                  cnt_q <= 4'(WIDTH - 1);
                  event_serial_out <= sh_q[WIDTH-1];
                  sh_q <= {sh_q[WIDTH-2:0], 1'b0};
               end else begin
                  cnt_q <= cnt_q - 4'h1;
               end
            end
            pmepr_pkg::SER_DATA: begin
               // MSB first, one bit per clock
               if (cnt_q == 4'h0) begin
                  st_q <= pmepr_pkg::SER_END;
                  event_serial_out <= 1'b1;
               end else begin
                  cnt_q <= cnt_q - 4'h1;
                  event_serial_out <= sh_q[WIDTH-1];
                  sh_q <= {sh_q[WIDTH-2:0], 1'b0};
               end
            end
            pmepr_pkg::SER_END: begin
               st_q <= pmepr_pkg::SER_IDLE;
               event_serial_out <= 1'b0;
               done <= 1'b1;
            end
            default: st_q <= pmepr_pkg::SER_IDLE;
         endcase
      end
   end

   a_start_two_high: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      $rose(busy) |-> event_serial_out ##1 event_serial_out)
      else $error("start mark not two clocks high");
   a_frame_length: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      $rose(busy) |-> ##(FRAME_CYC) done)
      else $error("frame length wrong");
   a_end_then_low: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      done |-> !event_serial_out)
      else $error("line not low after end mark");
   c_frame: cover property (@(posedge CLK_SYS) disable iff (!RESET_N) done);
endmodule

// ==== pmepr_pkt_decoder.sv ====
`timescale 1ns/100ps
module pmepr_pkt_decoder (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Serial line
   input wire logic event_serial_in,
   // Decoded packet
   output logic frame_start,
   output logic pkt_valid,
   output logic [7:0] pkt_byte,
   output logic frame_err
);
   // ===========================================
   // Frame decode
   // Error flag is sticky so a single bad frame cannot hide among good ones
   logic [3:0] ph_q;
   logic [7:0] sr_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ph_q <= 4'h0;
         sr_q <= 8'h00;
         frame_start <= 1'b0;
         pkt_valid <= 1'b0;
         pkt_byte <= 8'h00;
         frame_err <= 1'b0;
      end else begin
         frame_start <= 1'b0;
         pkt_valid <= 1'b0;
         case (ph_q)
            4'h0: if (event_serial_in) ph_q <= 4'h1;
            4'h1: begin
               frame_start <= event_serial_in;
               frame_err <= frame_err | !event_serial_in;
               ph_q <= event_serial_in ? 4'h2 : 4'h0;
            end
            4'hA: begin
               frame_err <= frame_err | !event_serial_in;
               ph_q <= 4'hB;
            end
            4'hB: begin
               frame_err <= frame_err | event_serial_in;
               pkt_byte <= sr_q;
               pkt_valid <= 1'b1;
               ph_q <= 4'h0;
            end
            default: begin
               sr_q <= {sr_q[6:0], event_serial_in};
               ph_q <= ph_q + 4'h1;
            end
         endcase
      end
   end
endmodule

// ==== tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
   // ===========================================
   // Setup
   localparam int C1 = 20;
   localparam int C5 = 40;
   localparam int C10 = 60;
   localparam logic [15:0] STS = pmepr_pkg::OFS_SMI_EVENT_STATUS;
   localparam logic [15:0] CTL = pmepr_pkg::OFS_PACKET_CONTROL_ENABLES;
   localparam logic [15:0] CSTP = pmepr_pkg::OFS_CLOCK_STOP_CONTROL;
   localparam logic [15:0] PKT = pmepr_pkg::OFS_EVENT_PACKET;
   logic clk_sys = 0, reset_n = 0, reg_wr = 0, reg_rd = 0;
   logic [15:0] reg_addr = 16'h0000;
   logic [31:0] reg_wdata = 32'h0, reg_rdata;
   logic vga_mem_trap = 0, vga_io_trap = 0, mgmt_irq_in_n = 1, vertical_irq_flag = 0;
   logic cache_miss = 0, cache_miss_write = 0, cache_miss_ifetch = 0;
   logic range_hit = 0, video_access = 0, suspend_request_n = 1;
   logic suspend_ack_n, clock_halt_mode, event_serial_out;
   logic frame_start, pkt_valid, frame_err;
   logic [7:0] pkt_byte;
   int n_fail = 0;
   int compares = 0;
   always #20 clk_sys = ~clk_sys;
   pmepr_regs #(.CYC_1MS(C1), .CYC_5MS(C5), .CYC_10MS(C10)) i_pmepr_regs (
      .CLK_SYS(clk_sys), .RESET_N(reset_n), .REG_WR(reg_wr), .REG_RD(reg_rd),
      .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
      .VGA_MEM_TRAP(vga_mem_trap), .VGA_IO_TRAP(vga_io_trap), .MGMT_IRQ_IN_N(mgmt_irq_in_n),
      .VERTICAL_IRQ_FLAG(vertical_irq_flag), .CACHE_MISS(cache_miss),
      .CACHE_MISS_WRITE(cache_miss_write), .CACHE_MISS_IFETCH(cache_miss_ifetch),
      .RANGE_HIT(range_hit), .VIDEO_ACCESS(video_access),
      .SUSPEND_REQUEST_N(suspend_request_n), .SUSPEND_ACK_N(suspend_ack_n),
      .CLOCK_HALT_MODE(clock_halt_mode), .EVENT_SERIAL_OUT(event_serial_out));
   pmepr_pkt_decoder i_pmepr_pkt_decoder (
      .clk(clk_sys), .rst_n(reset_n), .event_serial_in(event_serial_out),
      .frame_start(frame_start), .pkt_valid(pkt_valid), .pkt_byte(pkt_byte),
      .frame_err(frame_err));
   // ===========================================
   // Shared tasks
   task complete_run;
      $display("checks %0d, errors %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask
   task wr(input logic [15:0] a, input logic [31:0] d);
      @(negedge clk_sys);
      reg_wr = 1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clk_sys);
      reg_wr = 0;
   endtask
   task rdchk(input logic [15:0] a, input logic [31:0] exp, input string msg);
      @(negedge clk_sys);
      reg_rd = 1;
      reg_addr = a;
      @(negedge clk_sys);
      reg_rd = 0;
      chk(reg_rdata, exp, msg);
   endtask
   task automatic pulse(ref logic s);
      @(negedge clk_sys);
      s = ~s;
      @(negedge clk_sys);
      s = ~s;
   endtask
   task miss(input logic w, input logic f);
      @(negedge clk_sys);
      cache_miss = 1;
      cache_miss_write = w;
      cache_miss_ifetch = f;
      @(negedge clk_sys);
      cache_miss = 0;
   endtask
   task wait_frame(input logic [7:0] exp);
      int i;
      i = 0;
      do begin
         @(negedge clk_sys);
         i++;
      end while (pkt_valid !== 1'b1 && i < 300);
      chk({31'h0, pkt_valid}, 32'h1, "frame seen");
      chk({24'h0, pkt_byte}, {24'h0, exp}, "frame byte");
      chk({31'h0, frame_err}, 32'h0, "frame shape");
   endtask
   task quiet(input int n);
      int s;
      s = 0;
      repeat (n) begin
         @(negedge clk_sys);
         if (frame_start === 1'b1) s++;
      end
      chk(s, 0, "no frame expected");
   endtask
   task test_send(input logic [7:0] ctl, input logic [7:0] exp);
      wr(CTL, {24'h0, ctl | 8'h20});
      wait_frame(exp);
      rdchk(PKT, 32'h0, "packet cleared after send");
   endtask
   // ===========================================
   // Scenarios
   task t_reset;
      rdchk(STS, 32'h0, "status reset");
      rdchk(CTL, 32'h0, "control reset");
      rdchk(CSTP, 32'h0, "clock stop reset");
      rdchk(PKT, 32'h0, "packet reset");
      rdchk(16'h8510, 32'h0, "unmapped read");
      wr(PKT, 32'hC3);
      rdchk(PKT, 32'h0, "packet is read-only");
   endtask
   task t_status;
      pulse(vga_mem_trap);
      rdchk(STS, 32'h4, "memory trap flag");
      pulse(vga_io_trap);
      rdchk(STS, 32'h6, "io trap flag");
      pulse(mgmt_irq_in_n);
      rdchk(STS, 32'h7, "pin flag");
      wr(STS, 32'h0);
      rdchk(STS, 32'h7, "zero write keeps flags");
      wr(STS, 32'h2);
      rdchk(STS, 32'h5, "one clears only its flag");
      wr(STS, 32'h5);
      rdchk(STS, 32'h0, "all flags cleared");
   endtask
   task t_events;
      wr(CTL, 32'h7);
      pulse(vertical_irq_flag);
      miss(0, 0);
      pulse(range_hit);
      pulse(video_access);
      rdchk(PKT, 32'hC3, "events accumulate");
      pulse(vertical_irq_flag);
      rdchk(PKT, 32'hC3, "repeat event held");
      quiet(80);
      test_send(8'h07, 8'hC3);
      rdchk(CTL, 32'h7, "test bit reads zero");
   endtask
   task t_enables;
      wr(CTL, 32'h0);
      pulse(vertical_irq_flag);
      miss(1, 0);
      pulse(range_hit);
      pulse(video_access);
      rdchk(PKT, 32'h82, "disabled sources dropped");
      wr(CTL, 32'h4);
      miss(0, 0);
      rdchk(PKT, 32'h82, "read enable needs master");
      wr(CTL, 32'h2);
      miss(0, 0);
      miss(1, 1);
      rdchk(PKT, 32'h82, "read and fetch miss dropped");
      miss(1, 0);
      rdchk(PKT, 32'hC2, "write miss reported");
      test_send(8'h02, 8'hC2);
      wr(CTL, 32'h6);
      miss(0, 0);
      rdchk(PKT, 32'h40, "read miss reported");
      test_send(8'h06, 8'h40);
   endtask
   task t_interval;
      int n, g;
      for (int code = 1; code <= 3; code++) begin
         n = (code == 1) ? C1 : (code == 2) ? C5 : C10;
         wr(CTL, (code << 3) | 1);
         pulse(video_access);
         g = 0;
         do begin
            @(negedge clk_sys);
            g++;
         end while (frame_start !== 1'b1 && g < n + 20);
         chk({31'h0, frame_start}, 32'h1, "timed frame");
         g = 0;
         do begin
            @(negedge clk_sys);
            g++;
            video_access = pkt_valid;
         end while (frame_start !== 1'b1 && g < 3 * n);
         video_access = 0;
         chk(g, n, "interval between frames");
         wait_frame(8'h01);
         quiet(3 * n);
      end
      wr(CTL, 32'h0);
   endtask
   task t_suspend;
      // Clock is never stopped here; only the clock stop bit readback, the halt mode output and the acknowledge are checked
      wr(CSTP, 32'h1);
      rdchk(CSTP, 32'h1, "clock stop bit");
      chk({31'h0, clock_halt_mode}, 32'h1, "halt mode out");
      suspend_request_n = 0;
      @(negedge clk_sys);
      chk({31'h0, suspend_ack_n}, 32'h0, "suspend ack");
      wr(CSTP, 32'h0);
      chk({31'h0, suspend_ack_n}, 32'h1, "no ack in refresh mode");
      suspend_request_n = 1;
   endtask
   // ===========================================
   // Main sequence and watchdog
   initial begin
      repeat (10) @(negedge clk_sys);
      reset_n = 1;
      t_reset();
      t_status();
      t_events();
      t_enables();
      t_interval();
      t_suspend();
      complete_run();
   end
   initial begin
      #(40 * 20000);
      n_fail++;
      complete_run();
   end
endmodule
